// ==== hdl/ata_cmd_engine.sv ====
// Command engine for block writes, block size, DMA transfers and power modes.
// Assumes a one-cycle register port, a media sequencer on the same clock and
// a host sector strobe arriving from outside the clock domain.
`include "ata_cmd_map.svh"
`default_nettype none
module ata_cmd_engine #(
  parameter int TICK_CYCLES = `CLK_HZ * `TICK_PERIOD_S
) (
  input wire logic clk, // 20 MHz clock
  input wire logic rst, // Async reset, active high
  input wire ata_cmd_pkg::bus_type bus, // Register port
  output logic [7:0] rdata, // Read data, cycle after strobe
  input wire logic host_sector, // Host moved one sector, level toggle
  input wire logic media_done, // Media finished one sector, pulse
  input wire logic media_err, // Unrecoverable error with media_done
  input wire logic spin_ok, // Spindle at speed
  output var ata_cmd_pkg::media_type media, // Media request
  output logic spin_on, // Spindle motor enable
  output logic busy, // Busy
  output logic drq, // Data request
  output logic dmarq, // DMA request
  output logic intrq // Interrupt request
);
  import ata_cmd_pkg::*;

  localparam logic [11:0] STBY_DEF_S = 12'(`STBY_DEFAULT_MIN * 60);

  typedef struct packed {
    seq_type st;
    pm_type pm;
    logic [7:0] rdata;
    logic [7:0] feat;
    logic [7:0] sc;
    logic [27:0] lba;
    logic unit;
    logic [7:0] err;
    logic busy;
    logic drq;
    logic dmarq;
    logic intrq;
    logic mult_en;
    logic [4:0] blk_size;
    logic keep_mode;
    logic is_dma;
    logic is_wr;
    logic [8:0] remain;
    logic [4:0] blk_left;
    logic [4:0] med_left;
    logic med_req;
    logic spin_on;
    logic srst;
    logic [11:0] tmr_load;
    logic [11:0] tmr_cnt;
    logic [24:0] div;
    logic tick;
    logic [2:0] sync;
    logic host_lvl;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // ==========================================
  // Helpers
  // Smaller of remaining sectors and block size
  function automatic logic [4:0] blk_len(input logic [8:0] rem, input logic [4:0] size);
    blk_len = (rem < {4'h0, size}) ? rem[4:0] : size;
  endfunction : blk_len

  // Power sub-command index, or 4'hF when the opcode is not a power opcode
  function automatic logic [3:0] pwr_sub(input logic [7:0] code);
    logic [7:0] alt;
    alt = code - `OP_PWR_ALT;
    if (code[7:4] == `OP_PWR_GRP) begin
      pwr_sub = code[3:0];
    end else if (code >= `OP_PWR_ALT && alt[3:0] <= `SUB_LAST_ALT && alt[7:4] == 4'h0) begin
      pwr_sub = alt[3:0] + ((alt[3:0] >= 4'h4) ? 4'h1 : 4'h0);
    end else begin
      pwr_sub = 4'hF;
    end
  endfunction : pwr_sub

  // Starts the data phase of a transfer once the spindle runs
  function automatic state_type start_xfer(input state_type s);
    state_type n;
    n = s;
    if (s.is_dma && !s.is_wr) begin
      n.st = S_MEDIA;
      n.med_left = 5'h01;
      n.med_req = 1'b1;
    end else begin
      n.st = S_HOST;
      n.blk_left = s.is_dma ? 5'h01 : blk_len(s.remain, s.blk_size);
      n.busy = 1'b0;
      n.drq = 1'b1;
      n.dmarq = s.is_dma;
      n.intrq = n.intrq | !s.is_dma;
    end
    start_xfer = n;
  endfunction : start_xfer

  // Ends a command and raises its interrupt
  function automatic state_type finish(input state_type s, input logic [7:0] e);
    state_type n;
    n = s;
    n.st = S_READY;
    n.busy = 1'b0;
    n.drq = 1'b0;
    n.dmarq = 1'b0;
    n.intrq = 1'b1;
    n.err = e;
    n.tmr_cnt = s.tmr_load;
    finish = n;
  endfunction : finish

  // ==========================================
  // Next state
  always_comb begin
    logic host_edge;
    logic stat_rd;
    logic [3:0] sub;
    logic [7:0] rd;
    host_edge = 1'b0;
    stat_rd = 1'b0;
    sub = 4'hF;
    rd = 8'h00;
    s_next = s_reg;
    s_next.med_req = 1'b0;
    s_next.tick = 1'b0;
    s_next.rdata = 8'h00;
    // Host strobe through three flops; a change counts once the last two agree
    s_next.sync = {s_reg.sync[1:0], host_sector};
    host_edge = (s_reg.sync[2] == s_reg.sync[1]) && (s_reg.sync[2] != s_reg.host_lvl);
    s_next.host_lvl = host_edge ? s_reg.sync[2] : s_reg.host_lvl;
    // Second tick divider
    if (s_reg.div == 25'(TICK_CYCLES - 1)) begin
      s_next.div = 25'h0;
      s_next.tick = 1'b1;
    end else begin
      s_next.div = s_reg.div + 25'h1;
    end

    // Register reads
    if (bus.rd) begin
      unique case (bus.addr)
        `OFF_ERR_FEAT: rd = s_reg.err;
        `OFF_SCOUNT: rd = s_reg.sc;
        `OFF_SECTOR: rd = s_reg.lba[7:0];
        `OFF_TRK_LO: rd = s_reg.lba[15:8];
        `OFF_TRK_HI: rd = s_reg.lba[23:16];
        `OFF_HEAD: rd = {3'b111, s_reg.unit, s_reg.lba[27:24]};
        `OFF_STAT_CMD: begin
          rd[`ST_READY] = (s_reg.pm != PM_SLEEP);
          rd[`ST_BUSY] = s_reg.busy;
          rd[`ST_DRQ] = s_reg.drq;
          rd[`ST_ERR] = (s_reg.err != 8'h00);
          stat_rd = 1'b1;
        end
        default: rd = 8'h00;
      endcase
      s_next.rdata = rd;
    end
    // Status read clears the interrupt
    if (stat_rd) begin
      s_next.intrq = 1'b0;
    end

    // Task-file writes while idle; the command register starts a command
    if (bus.wr && !s_reg.busy && !s_reg.drq) begin
      unique case (bus.addr)
        `OFF_ERR_FEAT: s_next.feat = bus.wdata;
        `OFF_SCOUNT: s_next.sc = bus.wdata;
        `OFF_SECTOR: s_next.lba[7:0] = bus.wdata;
        `OFF_TRK_LO: s_next.lba[15:8] = bus.wdata;
        `OFF_TRK_HI: s_next.lba[23:16] = bus.wdata;
        `OFF_HEAD: begin
          s_next.lba[27:24] = bus.wdata[3:0];
          s_next.unit = bus.wdata[4];
        end
        default: ;
      endcase
    end

    // Command dispatch
    if (bus.wr && bus.addr == `OFF_STAT_CMD && s_reg.st == S_READY) begin
      s_next.err = 8'h00;
      s_next.busy = 1'b1;
      s_next.tmr_cnt = s_reg.tmr_load;
      s_next.remain = (s_reg.sc == 8'h00) ? 9'h100 : {1'b0, s_reg.sc};
      s_next.is_dma = (bus.wdata[7:1] == `OP_RD_DMA) || (bus.wdata[7:1] == `OP_WR_DMA);
      s_next.is_wr = (bus.wdata == `OP_WR_MULT) || (bus.wdata[7:1] == `OP_WR_DMA);
      sub = pwr_sub(bus.wdata);
      // block write aborts at once while block mode is off
      if (bus.wdata == `OP_WR_MULT && !s_reg.mult_en) begin
        s_next = finish(s_next, 8'(1) << `ER_ABRT);
      end else if (s_next.is_wr || s_next.is_dma) begin
        // spin up before access; busy shows for a cycle when already spinning, except on DMA reads
        s_next.st = S_SPIN;
        s_next.spin_on = 1'b1;
      end else if (bus.wdata == `OP_SET_MULT) begin
        if (s_reg.sc == 8'h00) begin
          s_next.mult_en = 1'b0;
          s_next = finish(s_next, 8'h00);
        end else if (s_reg.sc <= 8'h10 && (s_reg.sc & (s_reg.sc - 8'h01)) == 8'h00) begin
          s_next.blk_size = s_reg.sc[4:0];
          s_next.mult_en = 1'b1;
          s_next = finish(s_next, 8'h00);
        end else begin
          s_next.mult_en = 1'b0;
          s_next = finish(s_next, 8'(1) << `ER_ABRT);
        end
      end else if (bus.wdata == `OP_SET_FEAT) begin
        if (s_reg.feat == `FEAT_KEEP) begin
          s_next.keep_mode = 1'b1;
        end else if (s_reg.feat == `FEAT_DEFAULT) begin
          s_next.keep_mode = 1'b0;
        end
        s_next = finish(s_next, 8'h00);
      end else if (sub != 4'hF) begin
        if (sub == `SUB_STBY || sub == `SUB_IDLE) begin
          s_next.tmr_load = (s_reg.sc == 8'h00) ? STBY_DEF_S : 12'(s_reg.sc) * 12'(`STBY_STEP_S);
        end
        s_next = finish(s_next, 8'h00);
        unique case (sub)
          `SUB_STBY_NOW, `SUB_STBY: begin
            s_next.pm = PM_STBY;
            s_next.spin_on = 1'b0;
          end
          `SUB_IDLE_NOW, `SUB_IDLE: begin
            if (s_reg.pm == PM_STBY) begin
              s_next.st = S_SPIN;
              s_next.busy = 1'b1;
              s_next.intrq = s_reg.intrq;
              s_next.spin_on = 1'b1;
            end
          end
          `SUB_CHECK: begin
            s_next.sc = (s_reg.pm == PM_IDLE) ? `CHK_IDLE : `CHK_STBY;
          end
          `SUB_SLEEP: begin
            s_next.st = S_SLEEP;
            s_next.pm = PM_SLEEP;
            s_next.spin_on = 1'b0;
          end
          default: s_next.err = 8'(1) << `ER_ABRT;
        endcase
      end else begin
        s_next = finish(s_next, 8'(1) << `ER_ABRT);
      end
    end

    // Transfer sequence
    unique case (s_reg.st)
      S_SPIN: begin
        if (spin_ok) begin
          s_next.pm = PM_IDLE;
          s_next.tmr_cnt = s_reg.tmr_load;
          if (s_reg.is_wr || s_reg.is_dma) begin
            s_next = start_xfer(s_next);
          end else begin
            s_next = finish(s_next, 8'h00);
          end
        end
      end
      S_HOST: begin
        if (host_edge) begin
          s_next.blk_left = s_reg.blk_left - 5'h01;
          if (s_reg.blk_left == 5'h01) begin
            s_next.drq = 1'b0;
            s_next.dmarq = 1'b0;
            s_next.busy = 1'b1;
            if (s_reg.is_wr) begin
              s_next.st = S_MEDIA;
              s_next.med_left = s_reg.is_dma ? 5'h01 : blk_len(s_reg.remain, s_reg.blk_size);
              s_next.med_req = 1'b1;
            end else if (s_reg.remain == 9'h001) begin
              s_next = finish(s_next, 8'h00);
              s_next.sc = 8'h00;
            end else begin
              s_next.lba = s_reg.lba + 28'h1;
              s_next.remain = s_reg.remain - 9'h001;
              s_next.sc = s_next.remain[7:0];
              s_next.st = S_MEDIA;
              s_next.med_left = 5'h01;
              s_next.med_req = 1'b1;
            end
          end
        end
      end
      S_MEDIA: begin
        if (media_done) begin
          if (media_err) begin
            s_next = finish(s_next, 8'(1) << `ER_UNC);
          end else if (!s_reg.is_wr) begin
            s_next.st = S_HOST;
            s_next.blk_left = 5'h01;
            s_next.busy = 1'b0;
            s_next.drq = 1'b1;
            s_next.dmarq = 1'b1;
          end else if (s_reg.remain == 9'h001) begin
            s_next = finish(s_next, 8'h00);
            s_next.sc = 8'h00;
          end else begin
            s_next.lba = s_reg.lba + 28'h1;
            s_next.remain = s_reg.remain - 9'h001;
            s_next.sc = s_next.remain[7:0];
            s_next.med_left = s_reg.med_left - 5'h01;
            if (s_reg.med_left != 5'h01) begin
              s_next.med_req = 1'b1;
            end else begin
              s_next = start_xfer(s_next);
            end
          end
        end
      end
      default: ;
    endcase

    // Auto stand-by countdown in idle
    if (s_reg.st == S_READY && s_reg.pm == PM_IDLE && s_reg.tick) begin
      if (s_reg.tmr_cnt <= 12'h001) begin
        s_next.pm = PM_STBY;
        s_next.spin_on = 1'b0;
      end else begin
        s_next.tmr_cnt = s_reg.tmr_cnt - 12'h001;
      end
    end

    // Software reset on the rising edge of the control bit
    s_next.srst = (bus.wr && bus.addr == `OFF_DEVCTL) ? bus.wdata[`DEVCTL_SRST] : s_reg.srst;
    if (s_next.srst && !s_reg.srst) begin
      s_next.st = S_READY;
      s_next.busy = 1'b0;
      s_next.drq = 1'b0;
      s_next.dmarq = 1'b0;
      s_next.intrq = 1'b0;
      s_next.err = 8'h00;
      if (!s_reg.keep_mode) begin
        s_next.blk_size = `BLK_DEFAULT;
        s_next.mult_en = 1'b1;
      end
      if (s_reg.pm == PM_SLEEP) begin
        s_next.pm = PM_STBY;
      end
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      // spin up into idle at power-on
      s_reg.st <= S_SPIN;
      s_reg.pm <= PM_STBY;
      s_reg.busy <= 1'b1;
      s_reg.spin_on <= 1'b1;
      s_reg.mult_en <= 1'b1;
      s_reg.blk_size <= `BLK_DEFAULT;
      s_reg.tmr_load <= STBY_DEF_S;
      s_reg.tmr_cnt <= STBY_DEF_S;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign rdata = s_reg.rdata;
  assign media = '{req: s_reg.med_req, wr: s_reg.is_wr, lba: s_reg.lba};
  assign spin_on = s_reg.spin_on;
  assign busy = s_reg.busy;
  assign drq = s_reg.drq;
  assign dmarq = s_reg.dmarq;
  assign intrq = s_reg.intrq;
endmodule : ata_cmd_engine
`default_nettype wire

// ==== hdl/ata_cmd_map.svh ====
// Constants for the block-mode, DMA and power command engine.
// Assumes an 8-bit task-file port at 20 MHz driven by the drive's host-side logic.
`ifndef ATA_CMD_MAP_SVH
`define ATA_CMD_MAP_SVH
// ==========================================
// Task-file offsets
`define OFF_ERR_FEAT 4'h1
`define OFF_SCOUNT 4'h2
`define OFF_SECTOR 4'h3
`define OFF_TRK_LO 4'h4
`define OFF_TRK_HI 4'h5
`define OFF_HEAD 4'h6
`define OFF_STAT_CMD 4'h7
`define OFF_DEVCTL 4'h8
`define DEVCTL_SRST 2
// ==========================================
// Opcodes and feature codes
`define OP_WR_MULT 8'hC5
`define OP_SET_MULT 8'hC6
`define OP_RD_DMA 7'h64
`define OP_WR_DMA 7'h65
`define OP_SET_FEAT 8'hEF
`define OP_PWR_GRP 4'hE
`define OP_PWR_ALT 8'h94
`define FEAT_KEEP 8'h66
`define FEAT_DEFAULT 8'hCC
`define SUB_STBY_NOW 4'h0
`define SUB_IDLE_NOW 4'h1
`define SUB_STBY 4'h2
`define SUB_IDLE 4'h3
`define SUB_CHECK 4'h5
`define SUB_SLEEP 4'h6
`define SUB_LAST_ALT 4'h5
// ==========================================
// Status and error bits, reset values
`define ST_BUSY 7
`define ST_READY 6
`define ST_DRQ 3
`define ST_ERR 0
`define ER_UNC 6
`define ER_ABRT 2
`define BLK_DEFAULT 5'h10
`define CHK_IDLE 8'hFF
`define CHK_STBY 8'h00
// ==========================================
// Timing
`define CLK_HZ 20000000
`define TICK_PERIOD_S 1
`define STBY_STEP_S 5
`define STBY_DEFAULT_MIN 45
`endif

// ==== hdl/ata_cmd_pkg.sv ====
// Types for the block-mode, DMA and power command engine.
// Assumes the constants header is compiled alongside.
`default_nettype none
package ata_cmd_pkg;
  typedef enum logic [4:0] {
    S_READY = 5'b00001,
    S_SPIN = 5'b00010,
    S_HOST = 5'b00100,
    S_MEDIA = 5'b01000,
    S_SLEEP = 5'b10000
  } seq_type;
  typedef enum logic [2:0] {
    PM_IDLE = 3'b001,
    PM_STBY = 3'b010,
    PM_SLEEP = 3'b100
  } pm_type;
  // Request to the media side
  typedef struct packed {
    logic req;
    logic wr;
    logic [27:0] lba;
  } media_type;
  // Register port from software
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_type;
endpackage : ata_cmd_pkg
`default_nettype wire

// ==== tb/ata_cmd_engine_props.sv ====
// Checker for the command engine, bound to its ports.
// Assumes one clock domain with asynchronous active-high reset.
`default_nettype none
module ata_cmd_engine_props (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire ata_cmd_pkg::bus_type bus, // Register port
  input wire logic [7:0] rdata, // Read data
  input wire logic host_sector, // Host toggle
  input wire logic media_done, // Media done
  input wire logic media_err, // Media error
  input wire logic spin_ok, // Spindle ready
  input wire ata_cmd_pkg::media_type media, // Media request
  input wire logic spin_on, // Spindle enable
  input wire logic busy, // Busy
  input wire logic drq, // Data request
  input wire logic dmarq, // DMA request
  input wire logic intrq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ns;
  import ata_cmd_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Assertions
  a_rdata_idle: assert property (
    !$past(bus.rd) |-> rdata == 8'h00) else $error("read data outside read cycle");
  a_req_pulse: assert property (
    media.req |=> !media.req) else $error("media request longer than a cycle");
  a_req_spin: assert property (
    media.req |-> spin_on && busy && !drq) else $error("media request without spindle");
  a_block_irq: assert property (
    $rose(drq) && !dmarq |-> intrq) else $error("block start without interrupt");
  a_dma_pair: assert property (
    dmarq |-> drq && !busy) else $error("dma request without data request");
  a_dma_irq: assert property (
    $rose(intrq) |-> !dmarq) else $error("interrupt inside dma transfer");
  a_dma_phase: assert property (
    $fell(dmarq) && !intrq && !$past(bus.wr) |-> busy) else $error("dma phase gap");
  a_err_stop: assert property (
    media_done && media_err |=> !busy && !drq && intrq ##1 !media.req [*4])
    else $error("command did not stop on error");
  a_reset_spin: assert property (
    $fell(rst) |-> busy && spin_on && !drq) else $error("no spin-up after reset");
  a_media_next: assert property (
    media_done && !media_err |=> media.req || drq || (intrq && !busy))
    else $error("no follow-up after sector");
endmodule : ata_cmd_engine_props

bind ata_cmd_engine ata_cmd_engine_props u_props (.clk(clk), .rst(rst), .bus(bus),
  .rdata(rdata), .host_sector(host_sector), .media_done(media_done),
  .media_err(media_err), .spin_ok(spin_ok), .media(media), .spin_on(spin_on),
  .busy(busy), .drq(drq), .dmarq(dmarq), .intrq(intrq));
`default_nettype wire

// ==== tb/ata_host_model.sv ====
// Host controller model: moves sectors while the drive requests data.
// Assumes the gap exceeds the drive's input synchroniser delay.
`default_nettype none
module ata_host_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic drq, // Data request
  input wire logic dmarq, // DMA request
  input wire logic dma_armed, // DMA channel programmed
  input wire logic [3:0] gap, // Cycles between sectors
  output logic host_sector, // Sector toggle
  output logic [15:0] moves // Sectors moved
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // ==========================================
  // per-sector pacing at the gap, DMA only once armed
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      host_sector <= 1'b0;
      moves <= 16'h0000;
      cnt <= 4'h0;
    end else if (drq && (!dmarq || dma_armed) && cnt >= gap) begin
      host_sector <= ~host_sector;
      moves <= moves + 16'h0001;
      cnt <= 4'h0;
    end else if (cnt != 4'hF) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ata_host_model
`default_nettype wire

// ==== tb/ata_multi_dma_power_cmds_test.sv ====
// Self-checking bench for the command engine.
// Assumes a 20-cycle tick so stand-by timeouts stay short.
`include "ata_cmd_map.svh"
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch %0t %s", $time, m); end end
module ata_multi_dma_power_cmds_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ata_cmd_pkg::*;
  logic clk = 0;
  logic rst = 1;
  bus_type bus = '0;
  media_type media;
  logic [7:0] rdata, st, v;
  logic host_sector, spin_on, busy, drq, dmarq, intrq, pdrq, pirq;
  logic media_done = 0;
  logic media_err = 0;
  logic spin_ok = 0;
  logic armed = 0;
  logic [3:0] gap = 4'h7;
  logic [3:0] sp = 0;
  logic [2:0] mq = 0;
  logic [15:0] moves, m0;
  logic [27:0] ml;
  logic mw;
  logic cnt_clr = 0;
  logic [27:0] err_lba = '1;
  logic [7:0] sz [8] = '{1, 2, 3, 4, 8, 16, 32, 0};
  logic [7:0] dop [4] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB};
  int fail_count = 0;
  int n_checks = 0;
  int blk_n, irq_n, req_n, wt;
  ata_cmd_engine #(.TICK_CYCLES(20)) dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .host_sector(host_sector), .media_done(media_done), .media_err(media_err),
    .spin_ok(spin_ok), .media(media), .spin_on(spin_on), .busy(busy), .drq(drq),
    .dmarq(dmarq), .intrq(intrq));
  ata_host_model host (.clk(clk), .rst(rst), .drq(drq), .dmarq(dmarq), .dma_armed(armed),
    .gap(gap), .host_sector(host_sector), .moves(moves));
  always #25 clk = ~clk;
  // ==========================================
  // Media and spindle responders, event counters
  always @(posedge clk) begin
    mq <= {mq[1:0], media.req};
    if (media.req === 1'b1) ml <= media.lba;
    if (media.req === 1'b1) mw <= media.wr;
    media_done <= mq[2];
    media_err <= mq[2] && ml == err_lba;
    sp <= spin_on ? (sp == 4'hF ? sp : sp + 4'h1) : 4'h0;
    spin_ok <= sp == 4'hF;
    pdrq <= drq;
    pirq <= intrq;
    // Event counters clear on request from the test sequence
    if (cnt_clr) begin
      blk_n <= 0;
      irq_n <= 0;
      req_n <= 0;
    end else begin
      if (drq && !pdrq && intrq) blk_n <= blk_n + 1;
      if (intrq && !pirq) irq_n <= irq_n + 1;
      if (media.req) req_n <= req_n + 1;
    end
  end
  // ==========================================
  // Register port tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic wait_done;
    wt = 0;
    do begin
      @(posedge clk);
      #1 wt++;
    end while (!(intrq === 1'b1 && busy === 1'b0 && drq === 1'b0) && wt < 4000);
    `CHK(wt < 4000, 1'b1, "command hang")
    rd(`OFF_STAT_CMD, st);
  endtask : wait_done
  task automatic run(input logic [7:0] sc, input logic [7:0] op);
    wr(`OFF_SCOUNT, sc);
    wr(`OFF_STAT_CMD, op);
    wait_done;
  endtask : run
  task automatic xfer(input logic [7:0] sc, input logic [7:0] op, input logic [27:0] a);
    cnt_clr <= 1'b1;
    wr(`OFF_SECTOR, a[7:0]);
    cnt_clr <= 1'b0;
    wr(`OFF_TRK_LO, a[15:8]);
    wr(`OFF_TRK_HI, a[23:16]);
    wr(`OFF_HEAD, {4'hE, a[27:24]});
    m0 = moves;
    run(sc, op);
  endtask : xfer
  task automatic srst;
    wr(`OFF_DEVCTL, 8'h00);
    wr(`OFF_DEVCTL, 8'h04);
    wr(`OFF_DEVCTL, 8'h00);
  endtask : srst
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // Watchdog
  initial begin
    #(80000 * 50);
    fail_count++;
    $display("mismatch %0t watchdog expired", $time);
    report_and_stop;
  end
  // ==========================================
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_done;
    `CHK(st, 8'h40, "ready after power-on")
    run(8'h00, 8'hE5);
    rd(`OFF_SCOUNT, v);
    `CHK(v, `CHK_IDLE, "check power in idle")
    for (int i = 0; i < 8; i++) begin
      run(sz[i], `OP_SET_MULT);
      `CHK(st[0], !((sz[i] & (sz[i] - 8'h01)) == 8'h00 && sz[i] <= 8'h10), "size")
    end
    run(8'h01, `OP_WR_MULT);
    `CHK(st, 8'h41, "zero size disables")
    run(8'h03, `OP_SET_MULT);
    run(8'h01, `OP_WR_MULT);
    `CHK(st, 8'h41, "bad size disables")
    rd(`OFF_ERR_FEAT, v);
    `CHK(v, 8'h04, "abort code")
    run(8'h04, `OP_SET_MULT);
    xfer(8'h06, `OP_WR_MULT, 28'h10);
    `CHK(blk_n, 2, "block interrupts")
    `CHK(req_n, 6, "sectors written")
    `CHK(moves - m0, 16'd6, "sectors from host")
    rd(`OFF_SECTOR, v);
    `CHK(v, 8'h15, "last sector")
    err_lba = 28'h22;
    xfer(8'h08, `OP_WR_MULT, 28'h20);
    `CHK({st, blk_n[3:0], req_n[3:0]}, 16'h4113, "stop at error")
    rd(`OFF_SECTOR, v);
    `CHK(v, 8'h22, "failing sector")
    err_lba = '1;
    // single-sector retry of the failing sector
    run(8'h01, `OP_SET_MULT);
    xfer(8'h01, `OP_WR_MULT, 28'h22);
    `CHK(st, 8'h40, "retry")
    armed = 1'b1;
    for (int i = 0; i < 4; i++) begin
      gap = i[0] ? 4'hE : 4'h7;
      xfer(8'h03, dop[i], 28'h30);
      `CHK(irq_n, 1, "one dma interrupt")
      `CHK(moves - m0, 16'd3, "dma sectors")
      rd(`OFF_SECTOR, v);
      `CHK(v, 8'h32, "dma last sector")
      `CHK(mw, dop[i][1], "media direction")
    end
    err_lba = 28'h41;
    xfer(8'h04, 8'hCA, 28'h40);
    rd(`OFF_SECTOR, v);
    `CHK({st, v}, 16'h4141, "dma error sector")
    err_lba = '1;
    wr(`OFF_ERR_FEAT, `FEAT_KEEP);
    run(8'h00, `OP_SET_FEAT);
    run(8'h02, `OP_SET_MULT);
    srst;
    xfer(8'h04, `OP_WR_MULT, 28'h0);
    `CHK(blk_n, 2, "size kept")
    wr(`OFF_ERR_FEAT, `FEAT_DEFAULT);
    run(8'h00, `OP_SET_FEAT);
    srst;
    xfer(8'h04, `OP_WR_MULT, 28'h0);
    `CHK(blk_n, 1, "size restored")
    run(8'h00, 8'h96);
    `CHK(spin_on, 1'b0, "stand-by stops spindle")
    run(8'h5A, 8'h98);
    rd(`OFF_SCOUNT, v);
    `CHK(v, `CHK_STBY, "check power in stand-by")
    run(8'h5A, 8'hE1);
    rd(`OFF_SCOUNT, v);
    `CHK(v, 8'h5A, "count untouched")
    run(8'h00, 8'hE0);
    `CHK(spin_on, 1'b0, "stand-by now")
    run(8'h00, 8'h95);
    `CHK({st, spin_on}, 9'h081, "idle now")
    run(8'h00, 8'hE4);
    `CHK(st, 8'h41, "unknown power sub-command")
    run(8'h01, 8'h97);
    repeat (130) @(posedge clk);
    #1 `CHK(spin_on, 1'b0, "auto stand-by")
    xfer(8'h01, 8'hC8, 28'h05);
    `CHK(st, 8'h40, "read from stand-by")
    run(8'h00, 8'hE5);
    rd(`OFF_SCOUNT, v);
    `CHK(v, `CHK_IDLE, "idle after access")
    repeat (50) @(posedge clk);
    #1 `CHK(spin_on, 1'b1, "timer reloaded")
    repeat (80) @(posedge clk);
    #1 `CHK(spin_on, 1'b0, "timer expired")
    run(8'h00, 8'h99);
    `CHK(st[`ST_READY], 1'b0, "sleeping")
    wr(`OFF_SCOUNT, 8'h33);
    wr(`OFF_STAT_CMD, 8'hE5);
    repeat (10) @(posedge clk);
    rd(`OFF_SCOUNT, v);
    `CHK(v, 8'h33, "ignored in sleep")
    srst;
    run(8'h5A, 8'hE5);
    rd(`OFF_SCOUNT, v);
    `CHK(v, `CHK_STBY, "stand-by after reset")
    report_and_stop;
  end
endmodule : ata_multi_dma_power_cmds_test
`default_nettype wire
